// [hlim_pkg.sv]
// constants and carrier types for the host link interrupt event and mask block
package hlim_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] HLIM_EVENT_SET_OFS  = 8'h80;
  localparam logic [7:0] HLIM_EVENT_CLR_OFS  = 8'h84;
  localparam logic [7:0] HLIM_ENABLE_SET_OFS = 8'h88;
  localparam logic [7:0] HLIM_ENABLE_CLR_OFS = 8'h8c;

  // ---------------------------------------------------------------
  // bit positions shared by event and mask registers
  // ---------------------------------------------------------------
  localparam int HLIM_BIT_GATE      = 31;
  localparam int HLIM_BIT_MAKER     = 30;
  localparam int HLIM_BIT_SOFT      = 29;
  localparam int HLIM_BIT_RSVD28    = 28;
  localparam int HLIM_BIT_LATE_ACK  = 27;
  localparam int HLIM_BIT_PHY_REG   = 26;
  localparam int HLIM_BIT_LONG_CYC  = 25;
  localparam int HLIM_BIT_FATAL     = 24;
  localparam int HLIM_BIT_CYC_MISM  = 23;
  localparam int HLIM_BIT_MISS_CYC  = 22;
  localparam int HLIM_BIT_ISO_RX    = 7;
  localparam int HLIM_BIT_ISO_TX    = 6;
  localparam int HLIM_BIT_RESP_PKT  = 5;
  localparam int HLIM_BIT_REQ_PKT   = 4;
  localparam int HLIM_BIT_RX_RESP   = 3;
  localparam int HLIM_BIT_RX_REQ    = 2;
  localparam int HLIM_BIT_TX_RESP   = 1;
  localparam int HLIM_BIT_TX_REQ    = 0;

  // ---------------------------------------------------------------
  // field masks and reset values
  // ---------------------------------------------------------------
  // mask bits that hold state: all but 28 and 14..10
  localparam logic [31:0] HLIM_MASK_RW_BITS   = 32'hefff_83ff;
  // event bits that latch: no gate bit, no reserved, no live iso summaries
  localparam logic [31:0] HLIM_EVENT_LATCH    = 32'h6fff_833f;
  // event bits driven by the dma event port rather than the generic one
  localparam logic [31:0] HLIM_EVENT_DMA_BITS = 32'h0000_003f;
  localparam logic [31:0] HLIM_MASK_RESET     = 32'h0000_0000;
  localparam logic [31:0] HLIM_EVENT_RESET    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } hlim_bus_req_type;

  // one-cycle pulses from the asynchronous dma engines
  typedef struct packed {
    logic response_packet_stored;
    logic request_packet_stored;
    logic rx_response_dma_done;
    logic rx_request_dma_done;
    logic tx_response_dma_done;
    logic tx_request_dma_done;
  } hlim_dma_evt_type;

  // interrupt setting of the descriptor or command that just completed
  typedef struct packed {
    logic rx_response_irq;
    logic rx_request_irq;
    logic tx_response_irq;
    logic tx_request_irq;
  } hlim_dma_cond_type;

endpackage

// [hlim_irq_mask_events.sv]
// interrupt event and mask registers with the external interrupt output
//
// The strobed register port was decided locally.
module hlim_irq_mask_events #(
  parameter int ISO_RX_CTX = 4,
  parameter int ISO_TX_CTX = 4
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // register port
  input  wire hlim_pkg::hlim_bus_req_type bus_req,
  output logic [31:0]                    bus_rdata,
  // asynchronous dma event sources
  input  wire hlim_pkg::hlim_dma_evt_type dma_evt,
  input  wire hlim_pkg::hlim_dma_cond_type dma_cond,
  // one-cycle set pulses for the other latched event bits
  input  wire logic [31:0]               other_event_set,
  // per-context isochronous events and masks
  input  wire logic [ISO_RX_CTX-1:0]     iso_rx_ctx_event,
  input  wire logic [ISO_RX_CTX-1:0]     iso_rx_ctx_mask,
  input  wire logic [ISO_TX_CTX-1:0]     iso_tx_ctx_event,
  input  wire logic [ISO_TX_CTX-1:0]     iso_tx_ctx_mask,
  // status and interrupt
  output logic [31:0]                    enable_view,
  output logic                           irq
);
  import hlim_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] event_reg;
  logic [31:0] event_next;
  logic [31:0] event_view;
  logic [31:0] hw_set;
  logic [31:0] sw_set;
  logic [31:0] sw_clr;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        irq_reg;
  logic        irq_next;
  logic        iso_rx_live;
  logic        iso_tx_live;
  logic        hit_evt_set;
  logic        hit_evt_clr;
  logic        hit_msk_set;
  logic        hit_msk_clr;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // one compare per address; unmapped addresses match none of them
  assign hit_evt_set = (bus_req.addr == HLIM_EVENT_SET_OFS);
  assign hit_evt_clr = (bus_req.addr == HLIM_EVENT_CLR_OFS);
  assign hit_msk_set = (bus_req.addr == HLIM_ENABLE_SET_OFS);
  assign hit_msk_clr = (bus_req.addr == HLIM_ENABLE_CLR_OFS);

  // ---------------------------------------------------------------
  // hardware event collection
  // ---------------------------------------------------------------
  // dma sources land in bits 5..0, the rest comes from other blocks
  always_comb begin
    hw_set = other_event_set & HLIM_EVENT_LATCH & ~HLIM_EVENT_DMA_BITS;
    hw_set[HLIM_BIT_RESP_PKT] = dma_evt.response_packet_stored;
    hw_set[HLIM_BIT_REQ_PKT]  = dma_evt.request_packet_stored;
    hw_set[HLIM_BIT_RX_RESP]  = dma_evt.rx_response_dma_done & dma_cond.rx_response_irq;
    hw_set[HLIM_BIT_RX_REQ]   = dma_evt.rx_request_dma_done & dma_cond.rx_request_irq;
    hw_set[HLIM_BIT_TX_RESP]  = dma_evt.tx_response_dma_done & dma_cond.tx_response_irq;
    hw_set[HLIM_BIT_TX_REQ]   = dma_evt.tx_request_dma_done & dma_cond.tx_request_irq;
  end

  // ---------------------------------------------------------------
  // software set and clear of the event register
  // ---------------------------------------------------------------
  // software may also set bits, which is how event 29 is raised
  assign sw_set = (bus_req.wr && hit_evt_set) ? (bus_req.wdata & HLIM_EVENT_LATCH)
                                              : 32'h0000_0000;
  assign sw_clr = (bus_req.wr && hit_evt_clr) ? (bus_req.wdata & HLIM_EVENT_LATCH)
                                              : 32'h0000_0000;

  // set wins over clear so an event landing on a clear is never lost
  always_comb begin
    event_next = ((event_reg & ~sw_clr) | sw_set | hw_set) & HLIM_EVENT_LATCH;
  end

  // latched event bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_reg <= HLIM_EVENT_RESET;
    end else begin
      event_reg <= event_next;
    end
  end

  // ---------------------------------------------------------------
  // live isochronous summaries
  // ---------------------------------------------------------------
  // not latched: they follow the per-context registers directly
  assign iso_rx_live = |(iso_rx_ctx_event & iso_rx_ctx_mask);
  assign iso_tx_live = |(iso_tx_ctx_event & iso_tx_ctx_mask);

  // readable event image
  always_comb begin
    event_view = event_reg;
    event_view[HLIM_BIT_ISO_RX] = iso_rx_live;
    event_view[HLIM_BIT_ISO_TX] = iso_tx_live;
  end

  // ---------------------------------------------------------------
  // mask register
  // ---------------------------------------------------------------
  // reserved positions never take a one, so they always read zero
  always_comb begin
    mask_next = mask_reg;
    if (bus_req.wr && hit_msk_set) begin
      mask_next = mask_reg | (bus_req.wdata & HLIM_MASK_RW_BITS);
    end else if (bus_req.wr && hit_msk_clr) begin
      mask_next = mask_reg & ~(bus_req.wdata & HLIM_MASK_RW_BITS);
    end
  end

  // mask storage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_reg <= HLIM_MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign enable_view = mask_reg;

  // ---------------------------------------------------------------
  // interrupt generation
  // ---------------------------------------------------------------
  // bits 30 and 29..0 pair position by position; bit 31 only gates
  always_comb begin
    irq_next = mask_reg[HLIM_BIT_GATE]
             & (|(event_view[30:0] & mask_reg[30:0]));
  end

  // registered so the pin never glitches while bits are rewritten
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // both addresses of a pair return the same contents
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_evt_set || hit_evt_clr) begin
      rdata_next = event_view;
    end else if (hit_msk_set || hit_msk_clr) begin
      rdata_next = mask_reg;
    end
  end

  // data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign bus_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // bus sequences
  sequence s_mask_set_wr;
    bus_req.wr && hit_msk_set;
  endsequence

  sequence s_mask_clr_wr;
    bus_req.wr && hit_msk_clr;
  endsequence

  sequence s_mask_rd;
    bus_req.rd && (hit_msk_set || hit_msk_clr);
  endsequence

  sequence s_evt_clr_wr;
    bus_req.wr && hit_evt_clr;
  endsequence

  sequence s_evt_set_wr;
    bus_req.wr && hit_evt_set;
  endsequence

  sequence s_evt_rd;
    bus_req.rd && (hit_evt_set || hit_evt_clr);
  endsequence

  a_resp_pkt_latch: assert property (
    dma_evt.response_packet_stored |=> event_reg[HLIM_BIT_RESP_PKT])
    else $error("response packet event did not latch");

  a_req_pkt_latch: assert property (
    dma_evt.request_packet_stored |=> event_reg[HLIM_BIT_REQ_PKT])
    else $error("request packet event did not latch");

  a_rx_resp_cond: assert property (
    (dma_evt.rx_response_dma_done && dma_cond.rx_response_irq) |=> event_reg[HLIM_BIT_RX_RESP])
    else $error("receive response done did not latch");

  a_rx_req_cond: assert property (
    (dma_evt.rx_request_dma_done && dma_cond.rx_request_irq) |=> event_reg[HLIM_BIT_RX_REQ])
    else $error("receive request done did not latch");

  a_tx_resp_cond: assert property (
    (dma_evt.tx_response_dma_done && !dma_cond.tx_response_irq && !event_reg[HLIM_BIT_TX_RESP]
     && !(bus_req.wr && hit_evt_set && bus_req.wdata[HLIM_BIT_TX_RESP]))
    |=> !event_reg[HLIM_BIT_TX_RESP])
    else $error("transmit response done latched without its interrupt setting");

  a_tx_req_cond: assert property (
    (dma_evt.tx_request_dma_done && dma_cond.tx_request_irq) |=> event_reg[HLIM_BIT_TX_REQ])
    else $error("transmit request done did not latch");

  a_set_wins_clear: assert property (
    (s_evt_clr_wr and (hw_set != 32'h0000_0000)) |=> ((event_reg & $past(hw_set)) == $past(hw_set)))
    else $error("hardware event lost under a clear write");

  a_mask_set_path: assert property (
    s_mask_set_wr |=> mask_reg == ($past(mask_reg) | ($past(bus_req.wdata) & HLIM_MASK_RW_BITS)))
    else $error("mask set write wrong");

  a_mask_clr_path: assert property (
    s_mask_clr_wr |=> mask_reg == ($past(mask_reg) & ~$past(bus_req.wdata)))
    else $error("mask clear write wrong");

  a_mask_read_back: assert property (
    s_mask_rd |=> bus_rdata == $past(mask_reg))
    else $error("mask read returned wrong data");

  a_mask_rsvd_zero: assert property (
    mask_reg[HLIM_BIT_RSVD28] == 1'b0 && mask_reg[14:10] == 5'h00)
    else $error("reserved mask bit set");

  a_gate_blocks_irq: assert property (
    (!mask_reg[HLIM_BIT_GATE]) [*2] |-> !irq)
    else $error("interrupt raised with gate off");

  a_maker_pair_irq: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_MAKER] && event_reg[HLIM_BIT_MAKER]) |=> irq)
    else $error("maker-defined pair did not interrupt");

  a_soft_pair_irq: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_SOFT] && event_reg[HLIM_BIT_SOFT]) |=> irq)
    else $error("software-triggered pair did not interrupt");

  a_iso_live_sum: assert property (
    event_view[HLIM_BIT_ISO_RX] == (|(iso_rx_ctx_event & iso_rx_ctx_mask))
    && event_view[HLIM_BIT_ISO_TX] == (|(iso_tx_ctx_event & iso_tx_ctx_mask)))
    else $error("iso summary not live");

  a_irq_equation: assert property (
    ##1 irq == $past(mask_reg[HLIM_BIT_GATE] & (|(event_view[30:0] & mask_reg[30:0]))))
    else $error("interrupt output does not follow event and mask");

  a_unmapped_read: assert property (
    (bus_req.rd && !(hit_evt_set || hit_evt_clr || hit_msk_set || hit_msk_clr))
    |=> bus_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // ---------------------------------------------------------------
  // conditional dma sources, both outcomes
  // ---------------------------------------------------------------
  a_tx_resp_latch: assert property (
    (dma_evt.tx_response_dma_done && dma_cond.tx_response_irq) |=> event_reg[HLIM_BIT_TX_RESP])
    else $error("transmit response done did not latch");

  // a done pulse without its interrupt setting must leave the bit alone
  a_rx_resp_nocond: assert property (
    (dma_evt.rx_response_dma_done && !dma_cond.rx_response_irq && !event_reg[HLIM_BIT_RX_RESP]
     && !sw_set[HLIM_BIT_RX_RESP])
    |=> !event_reg[HLIM_BIT_RX_RESP])
    else $error("receive response done latched without its interrupt setting");

  a_rx_req_nocond: assert property (
    (dma_evt.rx_request_dma_done && !dma_cond.rx_request_irq && !event_reg[HLIM_BIT_RX_REQ]
     && !sw_set[HLIM_BIT_RX_REQ])
    |=> !event_reg[HLIM_BIT_RX_REQ])
    else $error("receive request done latched without its interrupt setting");

  a_tx_req_nocond: assert property (
    (dma_evt.tx_request_dma_done && !dma_cond.tx_request_irq && !event_reg[HLIM_BIT_TX_REQ]
     && !sw_set[HLIM_BIT_TX_REQ])
    |=> !event_reg[HLIM_BIT_TX_REQ])
    else $error("transmit request done latched without its interrupt setting");

  // ---------------------------------------------------------------
  // per-source pairs under the gate
  // ---------------------------------------------------------------
  // each pair alone must be enough; the equation check covers the rest
  a_late_ack_pair: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_LATE_ACK] && event_reg[HLIM_BIT_LATE_ACK]) |=> irq)
    else $error("late-acknowledge pair did not interrupt");

  a_phy_reg_pair: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_PHY_REG] && event_reg[HLIM_BIT_PHY_REG]) |=> irq)
    else $error("physical-layer register pair did not interrupt");

  a_long_cyc_pair: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_LONG_CYC] && event_reg[HLIM_BIT_LONG_CYC]) |=> irq)
    else $error("overlong-cycle pair did not interrupt");

  a_fatal_pair: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_FATAL] && event_reg[HLIM_BIT_FATAL]) |=> irq)
    else $error("fatal-error pair did not interrupt");

  a_cyc_mism_pair: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_CYC_MISM] && event_reg[HLIM_BIT_CYC_MISM]) |=> irq)
    else $error("cycle-inconsistency pair did not interrupt");

  a_miss_cyc_pair: assert property (
    (mask_reg[HLIM_BIT_GATE] && mask_reg[HLIM_BIT_MISS_CYC] && event_reg[HLIM_BIT_MISS_CYC]) |=> irq)
    else $error("missed-cycle pair did not interrupt");

  // ---------------------------------------------------------------
  // event register access
  // ---------------------------------------------------------------
  // only checked when no hardware set competes with the clear
  a_evt_clr_path: assert property (
    (s_evt_clr_wr and (hw_set == 32'h0000_0000))
    |=> event_reg == ($past(event_reg) & ~($past(bus_req.wdata) & HLIM_EVENT_LATCH)))
    else $error("event clear write wrong");

  // a set write always lands, whatever else happens in that cycle
  a_evt_set_path: assert property (
    s_evt_set_wr |=> ((event_reg & $past(bus_req.wdata) & HLIM_EVENT_LATCH)
                      == ($past(bus_req.wdata) & HLIM_EVENT_LATCH)))
    else $error("event set write wrong");

  a_evt_read_back: assert property (
    s_evt_rd |=> bus_rdata == $past(event_view))
    else $error("event read returned wrong data");

  a_evt_rsvd_zero: assert property (
    (event_reg & ~HLIM_EVENT_LATCH) == 32'h0000_0000)
    else $error("unlatched event position holds a one");

  // read data must not linger once its cycle is over
  a_rdata_one_cycle: assert property (
    !bus_req.rd |=> bus_rdata == 32'h0000_0000)
    else $error("read data stood beyond its cycle");

endmodule // hlim_irq_mask_events

// [hlim_irq_mask_events_bench.sv]
// self-checking bench for the host link interrupt event and mask block
module hlim_irq_mask_events_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hlim_pkg::*;

  // ---------------------------------------------------------------
  // stimulus, model state and counters
  // ---------------------------------------------------------------
  localparam int RXC = 4;
  localparam int TXC = 4;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  hlim_bus_req_type  bus_req = '0;
  hlim_dma_evt_type  dma_evt = '0;
  hlim_dma_cond_type dma_cond = '0;
  logic [31:0]       other_event_set = '0;
  logic [RXC-1:0]    iso_rx_ctx_event = '0;
  logic [RXC-1:0]    iso_rx_ctx_mask = '0;
  logic [TXC-1:0]    iso_tx_ctx_event = '0;
  logic [TXC-1:0]    iso_tx_ctx_mask = '0;
  logic [31:0]       bus_rdata;
  logic [31:0]       enable_view;
  logic              irq;
  logic [31:0]       ev_m, mk_m, rd_m, view_m;
  logic              irq_m;
  logic              chk_on = 1'b0;
  int                miscompares = 0;
  int                compares = 0;
  int                op;
  int                b;
  int                src_tab[14] = '{30, 29, 27, 26, 25, 24, 23, 22, 5, 4, 3, 2, 1, 0};
  logic [7:0]        addr_tab[5] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90};

  always #2 clk_sys = ~clk_sys;

  hlim_irq_mask_events #(.ISO_RX_CTX(RXC), .ISO_TX_CTX(TXC)) hlim_irq_mask_events_inst (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .dma_evt(dma_evt), .dma_cond(dma_cond), .other_event_set(other_event_set),
    .iso_rx_ctx_event(iso_rx_ctx_event), .iso_rx_ctx_mask(iso_rx_ctx_mask),
    .iso_tx_ctx_event(iso_tx_ctx_event), .iso_tx_ctx_mask(iso_tx_ctx_mask),
    .enable_view(enable_view), .irq(irq));

  // ---------------------------------------------------------------
  // cycle model: reads inputs before this edge's drives land
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      ev_m = '0;
      mk_m = '0;
      irq_m = 1'b0;
      rd_m = '0;
    end else begin
      view_m = ev_m;
      view_m[HLIM_BIT_ISO_RX] = |(iso_rx_ctx_event & iso_rx_ctx_mask);
      view_m[HLIM_BIT_ISO_TX] = |(iso_tx_ctx_event & iso_tx_ctx_mask);
      irq_m = mk_m[HLIM_BIT_GATE] & (|(view_m & mk_m));
      rd_m = '0;
      if (bus_req.rd) begin
        case (bus_req.addr)
          HLIM_EVENT_SET_OFS, HLIM_EVENT_CLR_OFS: rd_m = view_m;
          HLIM_ENABLE_SET_OFS, HLIM_ENABLE_CLR_OFS: rd_m = mk_m;
          default: rd_m = '0;
        endcase
      end
      // clear first so a same-cycle hardware set wins
      if (bus_req.wr) begin
        case (bus_req.addr)
          HLIM_EVENT_CLR_OFS: ev_m = ev_m & ~bus_req.wdata;
          HLIM_EVENT_SET_OFS: ev_m = ev_m | (bus_req.wdata & HLIM_EVENT_LATCH);
          HLIM_ENABLE_SET_OFS: mk_m = mk_m | (bus_req.wdata & HLIM_MASK_RW_BITS);
          HLIM_ENABLE_CLR_OFS: mk_m = mk_m & ~bus_req.wdata;
          default: ;
        endcase
      end
      ev_m = ev_m | (other_event_set & HLIM_EVENT_LATCH & ~HLIM_EVENT_DMA_BITS);
      ev_m[5:0] = ev_m[5:0] | (dma_evt & {2'b11, dma_cond});
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // outputs settle by the falling edge
  always @(negedge clk_sys) begin
    if (chk_on) begin
      check(bus_rdata, rd_m, "read data");
      check(enable_view, mk_m, "mask view");
      check({31'h0, irq}, {31'h0, irq_m}, "irq model");
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    check(bus_rdata, exp, "read");
  endtask

  task automatic irq_is(input logic exp);
    @(negedge clk_sys);
    check({31'h0, irq}, {31'h0, exp}, "irq");
  endtask

  // one-cycle event pulse on the dma port or the generic port
  task automatic pulse(input int n, input logic c);
    @(posedge clk_sys);
    if (n < 6) begin
      dma_evt <= hlim_dma_evt_type'(6'h1 << n);
      dma_cond <= hlim_dma_cond_type'(c ? 4'hf : 4'h0);
    end else other_event_set <= 32'h1 << n;
    @(posedge clk_sys);
    dma_evt <= '0;
    other_event_set <= '0;
  endtask

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #20000;
    miscompares++;
    end_sim;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'ha442));
    cyc(8);
    rst <= 1'b0;
    chk_on <= 1'b1;
    rd(HLIM_ENABLE_SET_OFS, 32'h0);
    // read-only zero bits never take a one
    wr(HLIM_ENABLE_SET_OFS, 32'hffff_ffff);
    rd(HLIM_ENABLE_SET_OFS, HLIM_MASK_RW_BITS);
    rd(HLIM_ENABLE_CLR_OFS, HLIM_MASK_RW_BITS);
    wr(HLIM_EVENT_SET_OFS, 32'hffff_ffff);
    rd(HLIM_EVENT_CLR_OFS, HLIM_EVENT_LATCH);
    wr(HLIM_ENABLE_CLR_OFS, 32'h8000_0000);
    cyc(1);
    irq_is(1'b0);
    wr(HLIM_ENABLE_SET_OFS, 32'h8000_0000);
    cyc(1);
    irq_is(1'b1);
    // each source alone under the gate
    foreach (src_tab[i]) begin
      b = src_tab[i];
      wr(HLIM_ENABLE_CLR_OFS, 32'hffff_ffff);
      wr(HLIM_EVENT_CLR_OFS, 32'hffff_ffff);
      wr(HLIM_ENABLE_SET_OFS, 32'h8000_0000 | (32'h1 << b));
      if (b < 4) begin
        pulse(b, 1'b0);
        cyc(2);
        irq_is(1'b0);
      end
      if (b == HLIM_BIT_SOFT) wr(HLIM_EVENT_SET_OFS, 32'h1 << b);
      else pulse(b, 1'b1);
      cyc(1);
      irq_is(1'b1);
      rd((i % 2) ? HLIM_EVENT_CLR_OFS : HLIM_EVENT_SET_OFS, 32'h1 << b);
      wr(HLIM_EVENT_CLR_OFS, 32'h1 << b);
      cyc(1);
      irq_is(1'b0);
    end
    // hardware set and software clear in one cycle
    @(posedge clk_sys);
    bus_req <= '{addr: HLIM_EVENT_CLR_OFS, wdata: 32'h0040_0000, wr: 1'b1, rd: 1'b0};
    other_event_set <= 32'h0040_0000;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    other_event_set <= '0;
    rd(HLIM_EVENT_SET_OFS, 32'h0040_0000);
    // unmapped place is ignored and reads zero
    wr(HLIM_ENABLE_CLR_OFS, 32'hffff_ffff);
    wr(8'h90, 32'hffff_ffff);
    rd(8'h90, 32'h0);
    rd(HLIM_ENABLE_CLR_OFS, 32'h0);
    // live iso summary needs event and context mask together
    wr(HLIM_EVENT_CLR_OFS, 32'hffff_ffff);
    wr(HLIM_ENABLE_SET_OFS, 32'h8000_00c0);
    @(posedge clk_sys);
    iso_rx_ctx_event <= 4'h2;
    iso_rx_ctx_mask <= 4'h1;
    cyc(2);
    irq_is(1'b0);
    @(posedge clk_sys);
    iso_rx_ctx_mask <= 4'h2;
    cyc(2);
    irq_is(1'b1);
    rd(HLIM_EVENT_SET_OFS, 32'h0000_0080);
    // random traffic on every input, back to back strobes
    repeat (400) begin
      @(posedge clk_sys);
      op = $urandom_range(2, 0);
      bus_req <= '{addr: addr_tab[$urandom_range(4, 0)], wdata: $urandom,
                   wr: (op == 1), rd: (op == 2)};
      dma_evt <= hlim_dma_evt_type'(6'($urandom & $urandom));
      dma_cond <= hlim_dma_cond_type'(4'($urandom));
      other_event_set <= $urandom & $urandom & 32'hdfff_ffff;
      iso_rx_ctx_event <= 4'($urandom);
      iso_rx_ctx_mask <= 4'($urandom);
      iso_tx_ctx_event <= 4'($urandom);
      iso_tx_ctx_mask <= 4'($urandom);
    end
    @(posedge clk_sys);
    bus_req <= '0;
    dma_evt <= '0;
    other_event_set <= '0;
    iso_rx_ctx_event <= '0;
    iso_tx_ctx_event <= '0;
    // second reset in mid-run
    @(posedge clk_sys);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rd(HLIM_ENABLE_SET_OFS, 32'h0);
    rd(HLIM_EVENT_SET_OFS, 32'h0);
    cyc(2);
    end_sim;
  end
endmodule // hlim_irq_mask_events_bench
